// >>> rtl/remote_port_defines.vh
// Constants for the remote command serial port: framing bytes, reply codes,
// baud timing at the 10 MHz system clock, and the supported command codes.
`ifndef REMOTE_PORT_DEFINES_VH
`define REMOTE_PORT_DEFINES_VH
`define CLK_HZ 10000000
`define BAUD_RATE 1200
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define DATA_BITS 8
`define BYTE_PREAMBLE 8'hfe
`define BYTE_END 8'hfd
`define CODE_OK 8'hfb
`define CODE_NG 8'hfa
`define CMD_QUERY_FREQ 8'h03
`define CMD_QUERY_MODE 8'h04
`define CMD_SET_FREQ 8'h05
`define CMD_SET_MODE 8'h06
`define FREQ_BYTES 4
`define RESET_STATION_ID 8'h01
`endif

// >>> rtl/serial_remote_command_port.v
// Remote command serial port: 1200 baud UART plus framed command interpreter.
// Assumes one 10 MHz clock; serial inputs are asynchronous pins.
//
// Contract
// (R1) The link runs 1200 baud, 8 data bits, 1 stop bit, no parity, both ways.
// (R2) One transmit bit stream drives both the logic-level and converted outputs.
// (R3) Logic-level, converted and rear-jack receive lines merge into one receiver input.
// (R4) The device holds a settable station identifier that the host must address.
// (R5) The identifier is shown as the decimal form of the stored address value; the code shows tens digit 9 for values above 99.
// (R6) The host waits for each reply before sending its next command.
// (R7) A successfully processed command is answered with an accept reply; the code answers successful queries with their data instead of FB.
// (R8) A malformed or unsupported command is answered with a reject reply; the code sends no reply to a frame whose FD comes before the command byte.
// (R9) Status queries are answered with the current frequency or mode data.
// (R10) Codes travel as hex bytes, first field first.
// (R11) Frames are FE FE, destination, source, command, optional data, FD.
// (R12) Frames whose destination does not match the identifier are ignored.
// (R13) Accept is FB and reject is FA, as the single payload byte of a reply.
// (R14) Replies carry the host address as destination and own id as source.
// (R15) A new prefix pair mid-frame restarts parsing; execution waits for FD.
`timescale 1ns/1ps
`include "remote_port_defines.vh"
module serial_remote_command_port #(
  parameter BIT_CYCLES = `BIT_CYCLES,
  parameter MAX_DATA = 8
) (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_rx_ttl,
  input wire i_rx_conv,
  input wire i_rx_jack,
  input wire i_id_load,
  input wire [7:0] i_id_value,
  output reg o_tx_ttl,
  output reg o_tx_conv,
  output reg [3:0] o_id_tens,
  output reg [3:0] o_id_ones,
  output reg [7:0] o_station_id,
  output reg [31:0] o_freq,
  output reg [7:0] o_mode,
  output reg [7:0] o_filter
);
  localparam S_IDLE = 8'h01;
  localparam S_PRE2 = 8'h02;
  localparam S_DST = 8'h04;
  localparam S_SRC = 8'h08;
  localparam S_CMD = 8'h10;
  localparam S_DATA = 8'h20;
  localparam S_EXEC = 8'h40;
  localparam S_SEND = 8'h80;
  // BCD digit check used for every frequency byte
  function bcd_ok;
    input [7:0] b;
    begin
      bcd_ok = (b[7:4] < 4'ha) && (b[3:0] < 4'ha);
    end
  endfunction
  // Receive: three lines are wire-ANDed since idle is high on each (see R3)
  reg rx_m_q;
  reg rx_s_q;
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= i_rx_ttl & i_rx_conv & i_rx_jack; // see (R3)
      rx_s_q <= rx_m_q;
    end
  end
  reg [15:0] rx_cnt_q;
  reg [3:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg rx_busy_q;
  reg rx_vld_q;
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_busy_q <= 1'b0;
      rx_vld_q <= 1'b0;
    end else begin
      rx_vld_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= BIT_CYCLES[15:0] >> 1;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        // Sample at bit centre: start, 8 data LSB first, stop (see R1)
        rx_cnt_q <= BIT_CYCLES[15:0] - 16'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0) begin
          if (rx_s_q)
            rx_busy_q <= 1'b0;
        end else if (rx_bit_q <= `DATA_BITS) begin
          rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
        end else begin
          rx_busy_q <= 1'b0;
          rx_vld_q <= rx_s_q; // Framing error drops the byte
        end
      end
    end
  end
  // Station identifier and its decimal panel form (see R4)
  wire [7:0] id_div = o_station_id / 8'd10;
  wire [7:0] id_rem = o_station_id % 8'd10;
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_station_id <= `RESET_STATION_ID;
      o_id_tens <= 4'h0;
      o_id_ones <= 4'h0;
    end else begin
      if (i_id_load)
        o_station_id <= i_id_value;
      o_id_tens <= (id_div > 8'd9) ? 4'h9 : id_div[3:0]; // see (R5)
      o_id_ones <= id_rem[3:0]; // see (R5)
    end
  end
  // Parser and reply builder
  reg [7:0] st_q;
  reg [7:0] host_q;
  reg [7:0] cmd_q;
  reg [7:0] dbuf_q [0:MAX_DATA-1];
  reg [3:0] dcnt_q;
  reg prev_fe_q;
  reg [7:0] rep_q [0:8];
  reg [3:0] rep_len_q;
  reg [3:0] rep_idx_q;
  reg tx_go_q;
  reg tx_busy_q;
  integer i;

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= S_IDLE;
      host_q <= 8'h00;
      cmd_q <= 8'h00;
      dcnt_q <= 4'h0;
      prev_fe_q <= 1'b0;
      rep_len_q <= 4'h0;
      rep_idx_q <= 4'h0;
      tx_go_q <= 1'b0;
      o_freq <= 32'h00000000;
      o_mode <= 8'h01;
      o_filter <= 8'h01;
      for (i = 0; i < 9; i = i + 1)
        rep_q[i] <= 8'h00;
      for (i = 0; i < MAX_DATA; i = i + 1)
        dbuf_q[i] <= 8'h00;
    end else begin
      tx_go_q <= 1'b0;
      if (rx_vld_q && st_q != S_EXEC && st_q != S_SEND)
        prev_fe_q <= (rx_sh_q == `BYTE_PREAMBLE);
      case (st_q)
        S_IDLE: begin
          if (rx_vld_q && rx_sh_q == `BYTE_PREAMBLE)
            st_q <= S_PRE2; // see (R11)
        end
        S_PRE2: begin
          if (rx_vld_q)
            st_q <= (rx_sh_q == `BYTE_PREAMBLE) ? S_DST : S_IDLE;
        end
        S_DST: begin
          if (rx_vld_q) begin
            if (rx_sh_q == `BYTE_PREAMBLE)
              st_q <= S_DST;
            else if (rx_sh_q == o_station_id)
              st_q <= S_SRC;
            else
              st_q <= S_IDLE; // see (R12)
          end
        end
        S_SRC, S_CMD, S_DATA: begin
          if (rx_vld_q) begin
            if (rx_sh_q == `BYTE_PREAMBLE && prev_fe_q) begin
              st_q <= S_DST; // see (R15)
            end else if (rx_sh_q == `BYTE_END) begin
              st_q <= (st_q == S_DATA) ? S_EXEC : S_IDLE; // see (R15)
            end else if (st_q == S_SRC) begin
              host_q <= rx_sh_q;
              st_q <= S_CMD;
            end else if (st_q == S_CMD) begin
              cmd_q <= rx_sh_q;
              dcnt_q <= 4'h0;
              st_q <= S_DATA;
            end else if (dcnt_q < MAX_DATA) begin
              dbuf_q[dcnt_q[2:0]] <= rx_sh_q; // see (R10)
              dcnt_q <= dcnt_q + 4'h1;
            end else begin
              dcnt_q <= 4'hf; // Overlong frame is rejected
            end
          end
        end
        S_EXEC: begin
          rep_q[0] <= `BYTE_PREAMBLE; // see (R11)
          rep_q[1] <= `BYTE_PREAMBLE;
          rep_q[2] <= host_q; // see (R14)
          rep_q[3] <= o_station_id; // see (R14)
          rep_q[4] <= `CODE_NG; // see (R8)
          rep_q[5] <= `BYTE_END;
          rep_q[6] <= `BYTE_END;
          rep_q[8] <= `BYTE_END;
          rep_len_q <= 4'h6;
          case (cmd_q)
            `CMD_QUERY_FREQ: begin
              if (dcnt_q == 4'h0) begin
                rep_q[4] <= o_freq[7:0]; // see (R9)
                rep_q[5] <= o_freq[15:8];
                rep_q[6] <= o_freq[23:16];
                rep_q[7] <= o_freq[31:24];
                rep_len_q <= 4'h9;
              end
            end
            `CMD_QUERY_MODE: begin
              if (dcnt_q == 4'h0) begin
                rep_q[4] <= o_mode; // see (R9)
                rep_q[5] <= o_filter;
                rep_len_q <= 4'h7;
              end
            end
            `CMD_SET_FREQ: begin
              if (dcnt_q == `FREQ_BYTES && bcd_ok(dbuf_q[0]) && bcd_ok(dbuf_q[1]) &&
                  bcd_ok(dbuf_q[2]) && bcd_ok(dbuf_q[3]) && dbuf_q[3] < 8'h30) begin
                o_freq <= {dbuf_q[3], dbuf_q[2], dbuf_q[1], dbuf_q[0] & 8'hf0};
                rep_q[4] <= `CODE_OK; // see (R7) (R13)
              end
            end
            `CMD_SET_MODE: begin
              if ((dcnt_q == 4'h1 || dcnt_q == 4'h2) && dbuf_q[0] < 8'h08 &&
                  (dcnt_q == 4'h1 || (dbuf_q[1] >= 8'h01 && dbuf_q[1] <= 8'h05))) begin
                o_mode <= dbuf_q[0];
                if (dcnt_q == 4'h2)
                  o_filter <= dbuf_q[1];
                rep_q[4] <= `CODE_OK; // see (R7) (R13)
              end
            end
            default: rep_q[4] <= `CODE_NG; // see (R8) (R13)
          endcase
          rep_idx_q <= 4'h0;
          st_q <= S_SEND;
        end
        S_SEND: begin
          // Host waits for the reply, so receive is not parsed meanwhile (see R6)
          if (!tx_busy_q && !tx_go_q) begin
            if (rep_idx_q == rep_len_q) begin
              st_q <= S_IDLE;
              prev_fe_q <= 1'b0;
            end else begin
              tx_go_q <= 1'b1;
              rep_idx_q <= rep_idx_q + 4'h1;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // Transmitter: 10-bit frame, one stream to both outputs (see R1)
  reg [9:0] tx_sh_q;
  reg [3:0] tx_bit_q;
  reg [15:0] tx_cnt_q;
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_sh_q <= 10'h3ff;
      tx_bit_q <= 4'h0;
      tx_cnt_q <= 16'h0000;
      tx_busy_q <= 1'b0;
      o_tx_ttl <= 1'b1;
      o_tx_conv <= 1'b1;
    end else begin
      if (tx_go_q) begin
        tx_sh_q <= {1'b1, rep_q[rep_idx_q - 4'h1], 1'b0}; // see (R10)
        tx_bit_q <= 4'h0;
        tx_cnt_q <= BIT_CYCLES[15:0] - 16'h0001;
        tx_busy_q <= 1'b1;
      end else if (tx_busy_q) begin
        if (tx_cnt_q != 16'h0000) begin
          tx_cnt_q <= tx_cnt_q - 16'h0001;
        end else begin
          tx_cnt_q <= BIT_CYCLES[15:0] - 16'h0001;
          tx_sh_q <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == 4'h9)
            tx_busy_q <= 1'b0;
        end
      end
      o_tx_ttl <= tx_busy_q ? tx_sh_q[0] : 1'b1; // see (R2)
      o_tx_conv <= tx_busy_q ? tx_sh_q[0] : 1'b1; // see (R2)
    end
  end
endmodule

// >>> dv/remote_port_monitor.sv
// Checker for the remote command port, bound to its top module.
// Assumes the sim BIT_CYCLES is at least 8.
`timescale 1ns/1ps
module remote_port_monitor #(parameter BIT_CYCLES = 16) (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_id_load,
  input wire [7:0] i_id_value,
  input wire o_tx_ttl,
  input wire o_tx_conv,
  input wire [3:0] o_id_tens,
  input wire [3:0] o_id_ones,
  input wire [7:0] o_station_id,
  input wire [31:0] o_freq,
  input wire [7:0] o_mode,
  input wire [7:0] o_filter
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence low_bit; !o_tx_ttl [*8]; endsequence
  sequence high_bit; o_tx_ttl [*8]; endsequence
  a_tx_same: assert property (o_tx_ttl == o_tx_conv)
    else $error("tx paths differ");
  a_low_len: assert property ($fell(o_tx_ttl) |-> low_bit)
    else $error("low bit too short");
  a_high_len: assert property ($rose(o_tx_ttl) |-> high_bit)
    else $error("high bit too short");
  a_id_load: assert property (i_id_load |=> o_station_id == $past(i_id_value))
    else $error("id not loaded");
  a_id_hold: assert property (!i_id_load |=> $stable(o_station_id))
    else $error("id changed unasked");
  a_ones_digit: assert property ($past(i_nrst) |-> o_id_ones == $past(o_station_id) % 10)
    else $error("ones digit wrong");
  a_tens_digit: assert property
    ($past(i_nrst) |-> o_id_tens == ($past(o_station_id) > 99 ? 9 : $past(o_station_id) / 10))
    else $error("tens digit wrong");
  a_freq_range: assert property (o_freq[31:24] < 8'h30 && o_freq[3:0] == 4'h0)
    else $error("frequency out of range");
  a_mode_range: assert property (o_mode < 8'h08 && o_filter inside {[1:5]})
    else $error("mode or filter out of range");
  // Settings change only on execution, which precedes the reply
  a_exec_idle: assert property ($changed(o_freq) |-> o_tx_ttl && $past(o_tx_ttl))
    else $error("setting changed mid reply");
endmodule
bind serial_remote_command_port remote_port_monitor #(.BIT_CYCLES(BIT_CYCLES)) mon_u (
  .i_sys_clk, .i_nrst, .i_id_load, .i_id_value, .o_tx_ttl, .o_tx_conv,
  .o_id_tens, .o_id_ones, .o_station_id, .o_freq, .o_mode, .o_filter);

// >>> dv/remote_host.sv
// Host computer model: sends command bytes, collects reply bytes.
// Assumes 8N1 at BIT_CYCLES clocks per bit, lines idle high.
`timescale 1ns/1ps
module remote_host #(parameter BIT_CYCLES = 16) (
  input wire i_sys_clk,
  input wire i_line,
  output reg o_line
);
  logic [7:0] rx_q[$];
  logic [7:0] rb;
  int stop_errs = 0;
  initial o_line = 1'b1;
  // Start bit, eight bits LSB first, one stop bit, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_sys_clk) o_line = f[i];
      repeat (BIT_CYCLES - 1) @(negedge i_sys_clk);
    end
  endtask
  initial forever begin
    @(negedge i_line);
    // Sample on the falling edge, away from the edge that moves the line
    repeat (BIT_CYCLES / 2) @(negedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(negedge i_sys_clk);
      rb[i] = i_line;
    end
    repeat (BIT_CYCLES) @(negedge i_sys_clk);
    if (i_line !== 1'b1) stop_errs++;
    rx_q.push_back(rb);
  end
endmodule

// >>> dv/tb_serial_remote_command_port.sv
// Bench for the remote command port with a host model on the serial lines.
// Assumes BIT_CYCLES cut to 16 so each byte takes 160 cycles and each frame 960 to 2080 cycles.
`timescale 1ns/1ps
module tb_serial_remote_command_port;
  localparam int BITS = 16;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_id_load = 1'b0;
  logic [7:0] i_id_value = 8'h00;
  logic [1:0] path = 2'h0;
  wire hl, o_tx_ttl, o_tx_conv;
  wire [3:0] o_id_tens, o_id_ones;
  wire [7:0] o_station_id, o_mode, o_filter;
  wire [31:0] o_freq;
  int fail_count = 0;
  int total_checks = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  serial_remote_command_port #(.BIT_CYCLES(BITS)) dut_u (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_rx_ttl(path != 2'h0 | hl),
    .i_rx_conv(path != 2'h1 | hl), .i_rx_jack(path != 2'h2 | hl),
    .i_id_load(i_id_load), .i_id_value(i_id_value), .o_tx_ttl(o_tx_ttl),
    .o_tx_conv(o_tx_conv), .o_id_tens(o_id_tens), .o_id_ones(o_id_ones),
    .o_station_id(o_station_id), .o_freq(o_freq), .o_mode(o_mode), .o_filter(o_filter));
  remote_host #(.BIT_CYCLES(BITS)) host_u (.i_sys_clk(i_sys_clk), .i_line(o_tx_ttl),
    .o_line(hl));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Byte k of a frame: prefix pair, body first field first, terminator
  function automatic logic [7:0] fbyte(input logic [87:0] b, input int n, input int k);
    if (k < 2) return 8'hfe;
    else if (k > n + 1) return 8'hfd;
    else return b[(n + 1 - k) * 8 +: 8];
  endfunction
  // Sends one framed command, then compares the whole reply
  task automatic xfer(input logic [87:0] b, input int nb, input logic [87:0] r, input int nr);
    host_u.rx_q.delete();
    for (int k = 0; k < nb + 3; k++)
      host_u.send_byte(fbyte(b, nb, k));
    // No new command until the whole reply is in
    for (int i = 0; i < 400 * BITS && host_u.rx_q.size() < nr + 3; i++)
      @(negedge i_sys_clk);
    if (nr == 0) check(host_u.rx_q.size(), 0);
    else if (host_u.rx_q.size() < nr + 3) begin
      check(host_u.rx_q.size(), nr + 3);
      results;
    end else begin
      for (int k = 0; k < nr + 3; k++)
        check(host_u.rx_q[k], fbyte(r, nr, k));
    end
    check(host_u.stop_errs, 0);
  endtask
  task automatic t_id(input logic [7:0] v, input logic [7:0] d);
    i_id_load = 1'b1;
    i_id_value = v;
    @(negedge i_sys_clk) i_id_load = 1'b0;
    check(o_station_id, v);
    @(negedge i_sys_clk) check({o_id_tens, o_id_ones}, d);
  endtask
  task automatic t_reset;
    repeat (20) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    check({o_station_id, o_mode, o_filter, o_tx_conv}, 25'h20203);
    check(o_freq, 32'h00000000);
    check({o_id_tens, o_id_ones}, 8'h01);
  endtask
  // Frequency set over the rear jack, accepted and stored
  task automatic t_set_freq;
    path = 2'h2;
    xfer(88'h2ae00575560314, 7, 88'he02afb, 3);
    check(o_freq, 32'h14035670);
  endtask
  // Frequency read back over the converted port, low byte first
  task automatic t_query_freq;
    path = 2'h1;
    xfer(88'h2ae003, 3, 88'he02a70560314, 6);
  endtask
  // Out-of-range frequency, unknown command and bad mode all refused
  task automatic t_refused;
    path = 2'h0;
    xfer(88'h2ae00500000031, 7, 88'he02afa, 3);
    xfer(88'h2ae007, 3, 88'he02afa, 3);
    xfer(88'h2ae00608, 4, 88'he02afa, 3);
    check(o_freq, 32'h14035670);
  endtask
  task automatic t_wrong_dest;
    path = 2'h0;
    xfer(88'h2be003, 3, 88'h0, 0);
  endtask
  // A fresh prefix pair mid-frame restarts the parse at the destination
  task automatic t_restart;
    path = 2'h0;
    xfer(88'h2ae006fefe2ae0060302, 10, 88'he02afb, 3);
    check({o_mode, o_filter}, 16'h0302);
  endtask
  // Mode read back, then a mode-only set keeps the filter
  task automatic t_query_mode;
    path = 2'h0;
    xfer(88'h2ae004, 3, 88'he02a0302, 4);
    xfer(88'h2ae00605, 4, 88'he02afb, 3);
    check({o_mode, o_filter}, 16'h0502);
    xfer(88'h2ae004, 3, 88'he02a0502, 4);
  endtask
  initial begin
    t_reset;
    t_id(8'h63, 8'h99);
    t_id(8'h7b, 8'h93);
    t_id(8'h2a, 8'h42);
    t_set_freq;
    t_query_freq;
    t_refused;
    t_wrong_dest;
    t_restart;
    t_query_mode;
    results;
  end
endmodule
